/* File: sim/pugf_filter_properties.sv */
// Concurrent checks on the parameter user group filter ports
`timescale 1ns/1ns
`include "pugf_cfg.svh"
module pugf_filter_checker #(
  parameter int SLOTS = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wrEn,
  input wire pugf_pkg::pugf_param_t wrNum,
  input wire pugf_pkg::pugf_param_t wrData,
  input wire logic rdEn,
  input wire pugf_pkg::pugf_param_t rdNum,
  input wire pugf_pkg::pugf_source_t rdSource,
  input wire logic rdValid,
  input wire logic rdAllowed,
  input wire logic rdOwn,
  input wire pugf_pkg::pugf_param_t rdData,
  input wire logic wrAck,
  input wire logic wrError,
  input wire pugf_pkg::pugf_param_t readViewSelector,
  input wire logic [4:0] groupCount
);
  import pugf_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_read_answer_timing: assert property (1 |=> rdValid == $past(rdEn)) else $error("read answer timing wrong");
  a_write_ack_timing: assert property (wrEn |=> wrAck) else $error("write not acknowledged");
  a_count_bound: assert property (groupCount <= SLOTS) else $error("group count too large");
  a_count_single_step: assert property ($changed(groupCount) |-> groupCount == 5'h00 ||
    groupCount == $past(groupCount) + 5'h01 || groupCount == $past(groupCount) - 5'h01) else $error("count jumped");
  a_entry_readback: assert property (rdEn && (rdNum == `PUGF_GROUP_ADD_NUM || rdNum == `PUGF_GROUP_REMOVE_NUM)
    ##1 rdAllowed |-> rdOwn && rdData == `PUGF_NO_SETTING) else $error("entry readback wrong");
  a_refused_silent: assert property (rdValid && !rdAllowed |-> !rdOwn && rdData == 16'h0000)
    else $error("refused read leaked data");
  a_batch_clear: assert property (wrEn && wrNum == `PUGF_GROUP_COUNT_NUM && wrData == `PUGF_NO_SETTING
    |-> ##2 groupCount == 5'h00) else $error("batch clear failed");
  a_count_other_noop: assert property (wrEn && wrNum == `PUGF_GROUP_COUNT_NUM && wrData != `PUGF_NO_SETTING
    |-> ##2 $stable(groupCount)) else $error("count write had effect");
  a_removal_noop: assert property (wrEn && wrNum == `PUGF_GROUP_REMOVE_NUM && wrData == `PUGF_NO_SETTING
    |=> !wrError ##1 $stable(groupCount)) else $error("removal of 9999 acted");
  a_always_readable: assert property (rdEn && (rdNum == `PUGF_WRITE_PROTECT_NUM || rdNum == `PUGF_READ_VIEW_NUM ||
    rdNum == `PUGF_CONTRAST_NUM) |=> rdAllowed) else $error("fixed entry refused");
  a_card_sees_all: assert property (rdEn && rdSource == PUGF_SRC_OPTION |=> rdAllowed) else $error("card read refused");
  a_selector_read: assert property (rdEn && rdNum == `PUGF_READ_VIEW_NUM
    |=> rdData == $past(readViewSelector)) else $error("selector readback wrong");
  c_group_refuse: cover property (rdEn && readViewSelector == `PUGF_VIEW_GROUP ##1 !rdAllowed);
  c_group_full: cover property (groupCount == SLOTS);
  c_write_error: cover property (wrError);
endmodule
bind pugf_filter pugf_filter_checker #(.SLOTS(SLOTS)) u_chk (.ref_clk(ref_clk), .srst(srst), .wrEn(wrEn),
  .wrNum(wrNum), .wrData(wrData), .rdEn(rdEn), .rdNum(rdNum), .rdSource(rdSource), .rdValid(rdValid),
  .rdAllowed(rdAllowed), .rdOwn(rdOwn), .rdData(rdData), .wrAck(wrAck), .wrError(wrError),
  .readViewSelector(readViewSelector), .groupCount(groupCount));

/* File: sim/pugf_panel_model.sv */
// Parameter table seen by the reader: simple and option classes
`timescale 1ns/1ns
module pugf_panel_model (
  input wire pugf_pkg::pugf_param_t rdNum,
  output logic rdIsSimple,
  output logic rdIsOption
);
  import pugf_pkg::*;
  // Low numbers simple-mode, one block owned by the option card
  assign rdIsSimple = rdNum < 16'h000f;
  assign rdIsOption = rdNum >= 16'h0300 && rdNum <= 16'h031f;
endmodule

/* File: sim/tb_parameter_user_group_filter.sv */
// Self-checking bench for the parameter user group filter
`timescale 1ns/1ns
module tb_parameter_user_group_filter;
  import pugf_pkg::*;
  logic ref_clk = 1'b0, srst = 1'b1, wrEn = 1'b0, rdEn = 1'b0;
  logic optionFitted = 1'b0, commCardPresent = 1'b0, unitAttached = 1'b0;
  pugf_param_t wrNum = 16'h0000, wrData = 16'h0000, rdNum = 16'h0000;
  pugf_param_t panelModeSource = 16'h0002, networkModeSource = 16'h270f;
  pugf_source_t rdSource = PUGF_SRC_PANEL;
  logic rdIsSimple, rdIsOption, rdValid, rdAllowed, rdOwn, wrAck, wrError, rAllow, lastErr;
  pugf_param_t rdData, readViewSelector, rData, view, rmv;
  logic [4:0] groupCount;
  logic [31:0] lfsr = 32'h47ca;
  pugf_param_t grp[$];
  pugf_param_t probe[6] = '{16'h000f, 16'h0010, 16'h03df, 16'h004d, 16'h0305, 16'h0003};
  pugf_param_t bad[6] = '{16'h004d, 16'h00a0, 16'h00ac, 16'h00ad, 16'h00ae, 16'h03e7};
  pugf_param_t nets[6] = '{16'h0000, 16'h0000, 16'h0001, 16'h270f, 16'h270f, 16'h270f};
  int fails = 0, comparisons = 0;
  always #10 ref_clk = ~ref_clk;
  pugf_panel_model u_model (.rdNum(rdNum), .rdIsSimple(rdIsSimple), .rdIsOption(rdIsOption));
  pugf_filter u_dut (.ref_clk(ref_clk), .srst(srst), .wrEn(wrEn), .wrNum(wrNum), .wrData(wrData), .rdEn(rdEn),
    .rdNum(rdNum), .rdSource(rdSource), .rdIsSimple(rdIsSimple), .rdIsOption(rdIsOption),
    .optionFitted(optionFitted), .commCardPresent(commCardPresent), .unitAttached(unitAttached),
    .panelModeSource(panelModeSource), .networkModeSource(networkModeSource), .rdValid(rdValid),
    .rdAllowed(rdAllowed), .rdOwn(rdOwn), .rdData(rdData), .wrAck(wrAck), .wrError(wrError),
    .readViewSelector(readViewSelector), .groupCount(groupCount));
  function automatic pugf_param_t rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return pugf_param_t'(lfsr % 32'd1000);
  endfunction
  function automatic logic in_grp(input pugf_param_t n);
    foreach (grp[i]) if (grp[i] == n) return 1'b1;
    return 1'b0;
  endfunction
  function automatic logic exp_allow(input pugf_param_t n, input pugf_source_t s);
    logic filt;
    logic simple;
    logic opt;
    opt = n >= 16'h0300 && n <= 16'h031f;
    simple = n < 16'h000f || (unitAttached && (n == 16'h000f || n == 16'h0010 || n == 16'h03df));
    filt = s != PUGF_SRC_RS485 || panelModeSource == 16'h0001 || networkModeSource == 16'h0000 ||
      (networkModeSource != 16'h0001 && commCardPresent);
    if (s == PUGF_SRC_OPTION || n == 16'h004d || n == 16'h00a0 || n == 16'h03df) return 1'b1;
    if (filt && view == 16'h270f) return simple && !opt;
    if (filt && view == 16'h0001) return in_grp(n);
    return !opt || optionFitted;
  endfunction
  task automatic chk(input pugf_param_t got, input pugf_param_t exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input pugf_param_t n, input pugf_param_t d);
    wrEn <= 1'b1;
    wrNum <= n;
    wrData <= d;
    @(posedge ref_clk);
    wrEn <= 1'b0;
    @(negedge ref_clk);
    lastErr = wrError;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic rd(input pugf_param_t n, input pugf_source_t s);
    rdEn <= 1'b1;
    rdNum <= n;
    rdSource <= s;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    @(negedge ref_clk);
    rAllow = rdAllowed;
    rData = rdData;
    @(posedge ref_clk);
  endtask
  task automatic rd_ck(input pugf_param_t n, input pugf_source_t s);
    rd(n, s);
    chk({15'h0000, rAllow}, {15'h0000, exp_allow(n, s)});
  endtask
  task automatic add(input pugf_param_t n);
    wr(16'h00ad, n);
    if (n <= 16'h03e7 && !in_grp(n) && grp.size() < 16 && !(n inside {16'h004d, 16'h00a0, [16'h00ac:16'h00ae]}))
      grp.push_back(n);
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(readViewSelector, 16'h0000);
    rd(16'h00ae, PUGF_SRC_PANEL);
    chk(rData, 16'h270f);
    for (int k = 0; k < 8; k++) begin
      view = k[0] ? 16'h270f : 16'h0000;
      unitAttached <= k[1];
      optionFitted <= k[2];
      wr(16'h00a0, view);
      repeat (5) @(posedge ref_clk);
      foreach (probe[i]) rd_ck(probe[i], PUGF_SRC_PANEL);
      repeat (6) rd_ck(rnd(), PUGF_SRC_PANEL);
    end
    view = 16'h0001;
    wr(16'h00a0, view);
    foreach (bad[i]) add(bad[i]);
    add(16'h03e7);
    add(16'h03e8);
    chk({15'h0000, lastErr}, 16'h0001);
    for (int i = 0; i < 40; i++) add(rnd());
    chk({11'h000, groupCount}, pugf_param_t'(grp.size()));
    foreach (grp[i]) rd_ck(grp[i], PUGF_SRC_PANEL);
    foreach (probe[i]) rd_ck(probe[i], PUGF_SRC_PANEL);
    repeat (4) rd_ck(rnd(), PUGF_SRC_OPTION);
    repeat (2) rd_ck(rnd(), PUGF_SRC_NONE);
    for (int k = 0; k < 6; k++) begin
      panelModeSource <= (k == 0) ? 16'h0001 : (k[0] ? 16'h0003 : 16'h0002);
      networkModeSource <= nets[k];
      commCardPresent <= k[0];
      repeat (5) @(posedge ref_clk);
      repeat (3) rd_ck(rnd(), PUGF_SRC_RS485);
    end
    rmv = grp[0];
    wr(16'h00ae, rmv);
    grp.delete(0);
    rd_ck(rmv, PUGF_SRC_PANEL);
    wr(16'h00ae, 16'h270f);
    chk({15'h0000, lastErr}, 16'h0000);
    wr(16'h00ac, 16'h0005);
    chk({11'h000, groupCount}, pugf_param_t'(grp.size()));
    view = 16'h0000;
    wr(16'h00a0, view);
    rd(16'h00ac, PUGF_SRC_PANEL);
    chk(rData, pugf_param_t'(grp.size()));
    wr(16'h00a0, 16'h0002);
    chk(readViewSelector, 16'h0000);
    wr(16'h00ac, 16'h270f);
    chk({11'h000, groupCount}, 16'h0000);
    wrap_up();
  end
endmodule

/* File: verilog/pugf_cfg.svh */
// Constants for the parameter user group filter
`ifndef PUGF_CFG_SVH
`define PUGF_CFG_SVH
`define PUGF_NO_SETTING 16'h270f
`define PUGF_VIEW_ALL 16'h0000
`define PUGF_VIEW_GROUP 16'h0001
`define PUGF_VIEW_RESET 16'h0000
`define PUGF_COUNT_RESET 5'h00
`define PUGF_PARAM_MAX 16'h03e7
`define PUGF_WRITE_PROTECT_NUM 16'h004d
`define PUGF_READ_VIEW_NUM 16'h00a0
`define PUGF_GROUP_COUNT_NUM 16'h00ac
`define PUGF_GROUP_ADD_NUM 16'h00ad
`define PUGF_GROUP_REMOVE_NUM 16'h00ae
`define PUGF_CONTRAST_NUM 16'h03df
`define PUGF_JOG_FREQ_NUM 16'h000f
`define PUGF_JOG_RAMP_NUM 16'h0010
`define PUGF_PANEL_SRC_RS485 16'h0001
`define PUGF_PANEL_SRC_PU 16'h0002
`define PUGF_PANEL_SRC_USB 16'h0003
`define PUGF_NET_SRC_OPT 16'h0000
`define PUGF_NET_SRC_RS485 16'h0001
`define PUGF_NET_SRC_AUTO 16'h270f
`endif

/* File: verilog/pugf_filter.sv */
// Parameter user group filter: view selector, group entries, read gating
`timescale 1ns/1ns
`include "pugf_cfg.svh"
module pugf_filter #(
  parameter int SLOTS = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wrEn,
  input wire pugf_pkg::pugf_param_t wrNum,
  input wire pugf_pkg::pugf_param_t wrData,
  input wire logic rdEn,
  input wire pugf_pkg::pugf_param_t rdNum,
  input wire pugf_pkg::pugf_source_t rdSource,
  input wire logic rdIsSimple,
  input wire logic rdIsOption,
  input wire logic optionFitted,
  input wire logic commCardPresent,
  input wire logic unitAttached,
  input wire pugf_pkg::pugf_param_t panelModeSource,
  input wire pugf_pkg::pugf_param_t networkModeSource,
  output logic rdValid,
  output logic rdAllowed,
  output logic rdOwn,
  output pugf_pkg::pugf_param_t rdData,
  output logic wrAck,
  output logic wrError,
  output pugf_pkg::pugf_param_t readViewSelector,
  output logic [4:0] groupCount
);
  import pugf_pkg::*;
  localparam int CW = $clog2(SLOTS+1);

  logic unitSync1;
  logic unitSync2;
  logic unitSync3;
  logic unitLevel;
  logic cardSync1;
  logic cardSync2;
  logic cardSync3;
  logic cardLevel;
  logic optSync1;
  logic optSync2;
  logic optSync3;
  logic optLevel;

  logic addReq;
  logic removeReq;
  logic clearReq;
  logic lookHit;
  logic [CW-1:0] listCount;
  logic viewAllowed;
  logic rs485Filtered;
  logic next_allowed;
  pugf_view_t viewCode;
  pugf_view_t effView;

  function automatic logic is_protected(input pugf_param_t n);
    return (n == `PUGF_WRITE_PROTECT_NUM) || (n == `PUGF_READ_VIEW_NUM)
      || (n == `PUGF_GROUP_COUNT_NUM) || (n == `PUGF_GROUP_ADD_NUM)
      || (n == `PUGF_GROUP_REMOVE_NUM);
  endfunction

  function automatic logic is_own_entry(input pugf_param_t n);
    return (n == `PUGF_READ_VIEW_NUM) || (n == `PUGF_GROUP_COUNT_NUM)
      || (n == `PUGF_GROUP_ADD_NUM) || (n == `PUGF_GROUP_REMOVE_NUM);
  endfunction

  function automatic logic is_view_value(input pugf_param_t v);
    return (v == `PUGF_NO_SETTING) || (v == `PUGF_VIEW_ALL) || (v == `PUGF_VIEW_GROUP);
  endfunction

  // Pin-level presence inputs: three stages, change taken when last two agree
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unitSync1 <= 1'b0;
      unitSync2 <= 1'b0;
      unitSync3 <= 1'b0;
    end else begin
      unitSync1 <= unitAttached;
      unitSync2 <= unitSync1;
      unitSync3 <= unitSync2;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cardSync1 <= 1'b0;
      cardSync2 <= 1'b0;
      cardSync3 <= 1'b0;
    end else begin
      cardSync1 <= commCardPresent;
      cardSync2 <= cardSync1;
      cardSync3 <= cardSync2;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      optSync1 <= 1'b0;
      optSync2 <= 1'b0;
      optSync3 <= 1'b0;
    end else begin
      optSync1 <= optionFitted;
      optSync2 <= optSync1;
      optSync3 <= optSync2;
    end
  end

  // Commit a pin level only once two stages agree
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unitLevel <= 1'b0;
    end else if (unitSync2 == unitSync3) begin
      unitLevel <= unitSync3;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cardLevel <= 1'b0;
    end else if (cardSync2 == cardSync3) begin
      cardLevel <= cardSync3;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      optLevel <= 1'b0;
    end else if (optSync2 == optSync3) begin
      optLevel <= optSync3;
    end
  end

  // Write decode of the group entry add, remove and clear commands
  always_comb begin
    addReq = wrEn && (wrNum == `PUGF_GROUP_ADD_NUM) && (wrData <= `PUGF_PARAM_MAX)
      && !is_protected(wrData);
    removeReq = wrEn && (wrNum == `PUGF_GROUP_REMOVE_NUM) && (wrData <= `PUGF_PARAM_MAX);
    clearReq = wrEn && (wrNum == `PUGF_GROUP_COUNT_NUM) && (wrData == `PUGF_NO_SETTING);
  end

  pugf_group_list #(
    .SLOTS(SLOTS)
  ) u_list (
    .ref_clk(ref_clk),
    .srst(srst),
    .addReq(addReq),
    .removeReq(removeReq),
    .clearReq(clearReq),
    .cmdNum(wrData),
    .lookNum(rdNum),
    .lookHit(lookHit),
    .count(listCount)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      readViewSelector <= `PUGF_VIEW_RESET;
    end else if (wrEn && (wrNum == `PUGF_READ_VIEW_NUM)) begin
      if (is_view_value(wrData)) begin
        readViewSelector <= wrData;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wrAck <= 1'b0;
    end else begin
      wrAck <= wrEn;
    end
  end

  // A selector or entry write with a value out of range is flagged
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wrError <= 1'b0;
    end else if (wrEn && (wrNum == `PUGF_READ_VIEW_NUM)) begin
      wrError <= !is_view_value(wrData);
    end else if (wrEn && ((wrNum == `PUGF_GROUP_ADD_NUM) || (wrNum == `PUGF_GROUP_REMOVE_NUM))) begin
      wrError <= !((wrData <= `PUGF_PARAM_MAX) || (wrData == `PUGF_NO_SETTING));
    end else begin
      wrError <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      groupCount <= `PUGF_COUNT_RESET;
    end else begin
      groupCount <= 5'(listCount);
    end
  end

  // View selection and source bypass
  always_comb begin
    case (readViewSelector)
      `PUGF_NO_SETTING: viewCode = PUGF_VW_SIMPLE;
      `PUGF_VIEW_ALL: viewCode = PUGF_VW_ALL;
      `PUGF_VIEW_GROUP: viewCode = PUGF_VW_GROUP;
      default: viewCode = PUGF_VW_ALL;
    endcase
  end

  // RS-485 bypass decided from the two command sources
  always_comb begin
    if (panelModeSource == `PUGF_PANEL_SRC_RS485) begin
      rs485Filtered = 1'b1;
    end else if (networkModeSource == `PUGF_NET_SRC_OPT) begin
      rs485Filtered = 1'b1;
    end else if (networkModeSource == `PUGF_NET_SRC_RS485) begin
      rs485Filtered = 1'b0;
    end else begin
      rs485Filtered = cardLevel;
    end
  end

  always_comb begin
    case (rdSource)
      PUGF_SRC_PANEL: effView = viewCode;
      PUGF_SRC_RS485: effView = rs485Filtered ? viewCode : PUGF_VW_ALL;
      PUGF_SRC_OPTION: effView = PUGF_VW_ALL;
      default: effView = viewCode;
    endcase
  end

  pugf_view_check u_check (
    .view(effView),
    .num(rdNum),
    .isSimple(rdIsSimple),
    .isOption(rdIsOption),
    .optionFitted(optLevel || (rdSource == PUGF_SRC_OPTION)),
    .groupHit(lookHit),
    .unitAttached(unitLevel),
    .allowed(viewAllowed)
  );

  always_comb begin
    next_allowed = viewAllowed;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdEn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdAllowed <= 1'b0;
    end else begin
      rdAllowed <= rdEn && next_allowed;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdOwn <= 1'b0;
    end else begin
      rdOwn <= rdEn && next_allowed && is_own_entry(rdNum);
    end
  end

  // Refused reads return zero so no filtered value leaks out
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdData <= 16'h0000;
    end else if (!rdEn || !next_allowed) begin
      rdData <= 16'h0000;
    end else if (rdNum == `PUGF_READ_VIEW_NUM) begin
      rdData <= readViewSelector;
    end else if (rdNum == `PUGF_GROUP_COUNT_NUM) begin
      rdData <= 16'(listCount);
    end else if ((rdNum == `PUGF_GROUP_ADD_NUM) || (rdNum == `PUGF_GROUP_REMOVE_NUM)) begin
      rdData <= `PUGF_NO_SETTING;
    end else begin
      rdData <= 16'h0000;
    end
  end
endmodule

/* File: verilog/pugf_group_list.sv */
// User group list: sixteen slots of parameter numbers with count
`timescale 1ns/1ns
`include "pugf_cfg.svh"
module pugf_group_list #(
  parameter int SLOTS = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic addReq,
  input wire logic removeReq,
  input wire logic clearReq,
  input wire pugf_pkg::pugf_param_t cmdNum,
  input wire pugf_pkg::pugf_param_t lookNum,
  output logic lookHit,
  output logic [$clog2(SLOTS+1)-1:0] count
);
  import pugf_pkg::*;
  localparam int CW = $clog2(SLOTS+1);
  pugf_param_t slotNum [SLOTS];
  logic [SLOTS-1:0] slotUsed;
  logic [SLOTS-1:0] cmdMatch;
  logic [SLOTS-1:0] lookMatch;
  logic [SLOTS-1:0] freeOne;

  function automatic logic [SLOTS-1:0] first_set(input logic [SLOTS-1:0] v);
    logic [SLOTS-1:0] r;
    r = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      cmdMatch[i] = slotUsed[i] && (slotNum[i] == cmdNum);
      lookMatch[i] = slotUsed[i] && (slotNum[i] == lookNum);
    end
    freeOne = first_set(~slotUsed);
  end

  assign lookHit = |lookMatch;

  always_ff @(posedge ref_clk) begin
    if (srst || clearReq) begin
      slotUsed <= '0;
    end else if (addReq && !(|cmdMatch) && (count != CW'(SLOTS))) begin
      slotUsed <= slotUsed | freeOne;
    end else if (removeReq) begin
      slotUsed <= slotUsed & ~cmdMatch;
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < SLOTS; i++) begin
      if (srst) begin
        slotNum[i] <= 16'h0000;
      end else if (addReq && freeOne[i] && !(|cmdMatch)) begin
        slotNum[i] <= cmdNum;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || clearReq) begin
      count <= '0;
    end else if (addReq && !(|cmdMatch) && (count != CW'(SLOTS))) begin
      count <= count + CW'(1);
    end else if (removeReq && (|cmdMatch)) begin
      count <= count - CW'(1);
    end
  end
endmodule

/* File: verilog/pugf_pkg.sv */
// Types for the parameter user group filter
package pugf_pkg;
  typedef logic [15:0] pugf_param_t;
  typedef enum logic [1:0] {
    PUGF_SRC_PANEL = 2'b00,
    PUGF_SRC_RS485 = 2'b01,
    PUGF_SRC_OPTION = 2'b10,
    PUGF_SRC_NONE = 2'b11
  } pugf_source_t;
  typedef enum logic [1:0] {
    PUGF_VW_SIMPLE = 2'b00,
    PUGF_VW_ALL = 2'b01,
    PUGF_VW_GROUP = 2'b10,
    PUGF_VW_OTHER = 2'b11
  } pugf_view_t;
endpackage

/* File: verilog/pugf_view_check.sv */
// Combinational read permission for one parameter number
`timescale 1ns/1ns
`include "pugf_cfg.svh"
module pugf_view_check (
  input wire pugf_pkg::pugf_view_t view,
  input wire pugf_pkg::pugf_param_t num,
  input wire logic isSimple,
  input wire logic isOption,
  input wire logic optionFitted,
  input wire logic groupHit,
  input wire logic unitAttached,
  output logic allowed
);
  import pugf_pkg::*;
  logic alwaysOk;
  logic simpleEff;

  always_comb begin
    alwaysOk = (num == `PUGF_WRITE_PROTECT_NUM) || (num == `PUGF_READ_VIEW_NUM)
      || (num == `PUGF_CONTRAST_NUM);
    simpleEff = isSimple || (unitAttached && ((num == `PUGF_JOG_FREQ_NUM)
      || (num == `PUGF_JOG_RAMP_NUM) || (num == `PUGF_CONTRAST_NUM)));
    case (view)
      PUGF_VW_SIMPLE: allowed = alwaysOk || (simpleEff && !isOption);
      PUGF_VW_ALL: allowed = alwaysOk || !isOption || optionFitted;
      PUGF_VW_GROUP: allowed = alwaysOk || groupHit;
      default: allowed = alwaysOk;
    endcase
  end
endmodule
